// ==== design/tioc_top.sv ====
/*
 * tioc_top: console terminal i/o control between a 12-bit host i/o bus and a
 * parallel printer-keyboard terminal. Decodes i/o transfer instructions under
 * two software-set device codes, moves 7-bit characters both ways.
 * Assumes the host bus timing signals are synchronous to pclk; terminal
 * inputs are asynchronous and are synchronised here.
 */
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
module tioc_top (
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tioc_pkg::TIOC_APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // host i/o bus
    input wire tioc_pkg::tioc_iot_t iot,
    input wire logic [0:tioc_pkg::TIOC_WORD_W-1] bus_data_in,
    output logic [0:tioc_pkg::TIOC_WORD_W-1] bus_data_out,
    output logic [0:tioc_pkg::TIOC_WORD_W-1] bus_data_oe,
    output tioc_pkg::tioc_resp_t resp,
    output logic bus_interrupt_request_n,
    // terminal
    input wire logic printer_ready_request,
    input wire logic keyboard_char_strobe_n,
    input wire logic [tioc_pkg::TIOC_CHAR_W-1:0] keyboard_char,
    output logic [tioc_pkg::TIOC_CHAR_W-1:0] printer_char,
    output logic printer_load_strobe_n
);
    import tioc_pkg::*;

    // --------------------------------------------------------------
    // terminal input synchronisers
    // --------------------------------------------------------------
    logic ready_sync;
    logic kstrobe_n_sync;
    logic [TIOC_CHAR_W-1:0] kchar_sync;
    logic ready_prev_reg;
    logic kstrobe_n_prev_reg;

    tioc_sync #(.WIDTH(1), .RST_VAL(1'b0)) u_sync_ready (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(printer_ready_request),
        .sync_out(ready_sync)
    );

    // strobe and character share one chain so they stay aligned
    tioc_sync #(.WIDTH(TIOC_CHAR_W + 1), .RST_VAL({1'b1, 7'h00})) u_sync_kbd (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({keyboard_char_strobe_n, keyboard_char}),
        .sync_out({kstrobe_n_sync, kchar_sync})
    );

    // edge detect history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_prev_reg <= 1'b0;
            kstrobe_n_prev_reg <= 1'b1;
        end else begin
            ready_prev_reg <= ready_sync;
            kstrobe_n_prev_reg <= kstrobe_n_sync;
        end
    end

    wire ready_rise = ready_sync && !ready_prev_reg;
    wire kstrobe_fall = !kstrobe_n_sync && kstrobe_n_prev_reg;

    // --------------------------------------------------------------
    // register slave
    // --------------------------------------------------------------
    logic [TIOC_CODE_W-1:0] kbd_code;
    logic [TIOC_CODE_W-1:0] prt_code;
    tioc_status_t status;

    tioc_apb_regs u_regs (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .status(status),
        .kbd_code(kbd_code),
        .prt_code(prt_code)
    );

    // --------------------------------------------------------------
    // instruction decode
    // --------------------------------------------------------------
    wire [TIOC_CODE_W-1:0] dev_code = iot.mem_data[TIOC_CODE_MSB +: TIOC_CODE_W];
    wire [TIOC_OP_W-1:0] op = iot.mem_data[TIOC_OP_MSB +: TIOC_OP_W];
    // keyboard code wins if software sets both codes equal
    wire sel_kbd = iot.iot_active && (dev_code == kbd_code);
    wire sel_prt = iot.iot_active && (dev_code == prt_code) && !sel_kbd;

    // the six keyboard and six printer instructions
    wire do_kcf = sel_kbd && (op == TIOC_OP_KBD_FLAG_CLEAR);
    wire do_ksf = sel_kbd && (op == TIOC_OP_KBD_FLAG_SKIP);
    wire do_kcc = sel_kbd && (op == TIOC_OP_KBD_FLAG_ACC_CLEAR);
    wire do_krs = sel_kbd && (op == TIOC_OP_KBD_OR_READ);
    wire do_kie = sel_kbd && (op == TIOC_OP_IRQ_ENABLE_WRITE);
    wire do_krb = sel_kbd && (op == TIOC_OP_KBD_READ_CLEAR);
    wire do_tfl = sel_prt && (op == TIOC_OP_PRT_FLAG_SET);
    wire do_tsf = sel_prt && (op == TIOC_OP_PRT_FLAG_SKIP);
    wire do_tcf = sel_prt && (op == TIOC_OP_PRT_FLAG_CLEAR);
    wire do_tpc = sel_prt && (op == TIOC_OP_PRT_LOAD);
    wire do_tsk = sel_prt && (op == TIOC_OP_EITHER_FLAG_SKIP);
    wire do_tls = sel_prt && (op == TIOC_OP_PRT_LOAD_AND_CLEAR);

    // --------------------------------------------------------------
    // once-per-instruction pulse three
    // --------------------------------------------------------------
    logic tp3_prev_reg;
    logic done_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tp3_prev_reg <= 1'b0;
        end else begin
            tp3_prev_reg <= iot.timing_pulse_three;
        end
    end

    wire tp3_edge = iot.timing_pulse_three && !tp3_prev_reg;
    wire act = tp3_edge && iot.iot_active && !done_reg;
    wire tp3_any = tp3_edge;

    // one action per instruction, rearmed when the instruction ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            done_reg <= 1'b0;
        end else if (!iot.iot_active) begin
            done_reg <= 1'b0;
        end else if (act) begin
            done_reg <= 1'b1;
        end
    end

    // --------------------------------------------------------------
    // flags, enable latch, character registers
    // --------------------------------------------------------------
    logic kbd_flag_reg;
    logic prt_flag_reg;
    logic ie_reg;
    logic strobe_latch_reg;
    logic [TIOC_CHAR_W-1:0] kchar_reg;
    logic [TIOC_CHAR_W-1:0] pchar_reg;

    wire prt_load = act && (do_tpc || do_tls);
    wire prt_set = ready_rise || (act && do_tfl);
    wire prt_clr = act && (do_tcf || do_tls);
    wire kbd_clr = act && (do_kcf || do_kcc || do_krb);

    // set wins over clear on both flags
    wire prt_flag_next = prt_set || (prt_flag_reg && !prt_clr);
    wire kbd_flag_next = kstrobe_fall || (kbd_flag_reg && !kbd_clr);
    // strobe latch drops at the next pulse three edge, whether or not an instruction is active
    wire strobe_next = prt_load || (strobe_latch_reg && !tp3_any);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prt_flag_reg <= 1'b0;
            kbd_flag_reg <= 1'b0;
            strobe_latch_reg <= 1'b0;
        end else begin
            prt_flag_reg <= prt_flag_next;
            kbd_flag_reg <= kbd_flag_next;
            strobe_latch_reg <= strobe_next;
        end
    end

    // interrupt enable from accumulator bit 11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ie_reg <= TIOC_IE_RST;
        end else if (act && do_kie) begin
            ie_reg <= bus_data_in[TIOC_IE_BIT];
        end
    end

    // input register, changed only by the keyboard strobe
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kchar_reg <= 7'h00;
        end else if (kstrobe_fall) begin
            kchar_reg <= kchar_sync;
        end
    end

    // output register from data bits 5..11
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pchar_reg <= 7'h00;
        end else if (prt_load) begin
            pchar_reg <= bus_data_in[TIOC_CHAR_MSB +: TIOC_CHAR_W];
        end
    end

    // --------------------------------------------------------------
    // terminal outputs
    // --------------------------------------------------------------
    assign printer_char = pchar_reg;
    assign printer_load_strobe_n = !(strobe_latch_reg && iot.time_state_two);

    // --------------------------------------------------------------
    // host bus answers
    // --------------------------------------------------------------
    wire kbd_read = do_krs || do_krb;
    wire any_flag_irq = ie_reg && (kbd_flag_reg || prt_flag_reg);

    assign resp.internal_io_claim = sel_kbd || sel_prt;
    assign resp.skip = (do_ksf && kbd_flag_reg)
                     || (do_tsf && prt_flag_reg)
                     || (do_tsk && any_flag_irq);
    assign resp.ac_transfer_ctl_a_n = !(do_kcc || do_krb);
    assign resp.ac_transfer_ctl_b_n = !(do_kcc || do_krb || do_krs);
    assign bus_interrupt_request_n = !any_flag_irq;

    // read data: character on bits 5..11, bit 4 forced high
    assign bus_data_out = {4'h0, 1'b1, kchar_reg};
    assign bus_data_oe = kbd_read ? 12'h0FF : 12'h000;

    // --------------------------------------------------------------
    // status toward software
    // --------------------------------------------------------------
    assign status.kbd_flag = kbd_flag_reg;
    assign status.prt_flag = prt_flag_reg;
    assign status.irq_enable = ie_reg;
    assign status.strobe_latch = strobe_latch_reg;
    assign status.kbd_char = kchar_reg;
    assign status.prt_char = pchar_reg;
endmodule : tioc_top

// ==== shared/tioc_pkg.sv ====
/*
 * tioc_pkg: constants and carrier types for the console terminal i/o control.
 * Assumes a 12-bit host i/o bus numbered 0 (msb) to 11 (lsb) and a 32-bit apb.
 */
package tioc_pkg;

    // ------------------------------------------------------------------
    // host bus word layout
    // ------------------------------------------------------------------
    localparam int TIOC_WORD_W = 12;
    localparam int TIOC_CODE_W = 6;
    localparam int TIOC_OP_W = 3;
    localparam int TIOC_CHAR_W = 7;
    localparam int TIOC_CODE_MSB = 3;   // device code in memory data bits 3..8
    localparam int TIOC_OP_MSB = 9;     // operation code in memory data bits 9..11
    localparam int TIOC_CHAR_MSB = 5;   // character in data bits 5..11
    localparam int TIOC_MARK_BIT = 4;   // forced one on keyboard reads
    localparam int TIOC_IE_BIT = 11;    // accumulator bit for the enable latch

    // ------------------------------------------------------------------
    // default device codes and reset values
    // ------------------------------------------------------------------
    localparam logic [5:0] TIOC_KBD_CODE_RST = 6'h03;
    localparam logic [5:0] TIOC_PRT_CODE_RST = 6'h04;
    localparam logic TIOC_IE_RST = 1'b1;

    // ------------------------------------------------------------------
    // operation codes under the keyboard code
    // ------------------------------------------------------------------
    localparam logic [2:0] TIOC_OP_KBD_FLAG_CLEAR = 3'h0;
    localparam logic [2:0] TIOC_OP_KBD_FLAG_SKIP = 3'h1;
    localparam logic [2:0] TIOC_OP_KBD_FLAG_ACC_CLEAR = 3'h2;
    localparam logic [2:0] TIOC_OP_KBD_OR_READ = 3'h4;
    localparam logic [2:0] TIOC_OP_IRQ_ENABLE_WRITE = 3'h5;
    localparam logic [2:0] TIOC_OP_KBD_READ_CLEAR = 3'h6;

    // ------------------------------------------------------------------
    // operation codes under the printer code
    // ------------------------------------------------------------------
    localparam logic [2:0] TIOC_OP_PRT_FLAG_SET = 3'h0;
    localparam logic [2:0] TIOC_OP_PRT_FLAG_SKIP = 3'h1;
    localparam logic [2:0] TIOC_OP_PRT_FLAG_CLEAR = 3'h2;
    localparam logic [2:0] TIOC_OP_PRT_LOAD = 3'h4;
    localparam logic [2:0] TIOC_OP_EITHER_FLAG_SKIP = 3'h5;
    localparam logic [2:0] TIOC_OP_PRT_LOAD_AND_CLEAR = 3'h6;

    // ------------------------------------------------------------------
    // apb register map
    // ------------------------------------------------------------------
    localparam int TIOC_APB_ADDR_W = 12;
    localparam logic [11:0] TIOC_ADDR_CODES = 12'h000;
    localparam logic [11:0] TIOC_ADDR_STATUS = 12'h004;
    localparam int TIOC_CODES_KBD_LSB = 0;   // codes reg: keyboard code [5:0]
    localparam int TIOC_CODES_PRT_LSB = 8;   // codes reg: printer code [13:8]
    localparam int TIOC_ST_KBD_FLAG = 0;
    localparam int TIOC_ST_PRT_FLAG = 1;
    localparam int TIOC_ST_IE = 2;
    localparam int TIOC_ST_STROBE = 3;
    localparam int TIOC_ST_KCHAR_LSB = 8;
    localparam int TIOC_ST_PCHAR_LSB = 16;

    // ------------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic iot_active;                    // an i/o transfer instruction executes
        logic [0:TIOC_WORD_W-1] mem_data;    // instruction word
        logic time_state_two;                // level
        logic timing_pulse_three;            // pulse
    } tioc_iot_t;

    typedef struct packed {
        logic internal_io_claim;
        logic skip;
        logic ac_transfer_ctl_a_n;
        logic ac_transfer_ctl_b_n;
    } tioc_resp_t;

    typedef struct packed {
        logic kbd_flag;
        logic prt_flag;
        logic irq_enable;
        logic strobe_latch;
        logic [TIOC_CHAR_W-1:0] kbd_char;
        logic [TIOC_CHAR_W-1:0] prt_char;
    } tioc_status_t;

endpackage : tioc_pkg

// ==== design/tioc_sync.sv ====
/*
 * tioc_sync: three-flop input synchroniser with agreement filter.
 * Assumes asynchronous inputs; output changes once stages two and three agree.
 */
`timescale 1ns/1ps
module tioc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    initial begin
        if (WIDTH < 1) $error("tioc_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] s1_reg;
    logic [WIDTH-1:0] s2_reg;
    logic [WIDTH-1:0] s3_reg;
    logic [WIDTH-1:0] out_reg;
    wire [WIDTH-1:0] agree = ~(s2_reg ^ s3_reg);

    // --------------------------------------------------------------
    // shift chain, per-bit accept on agreement
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
            out_reg <= RST_VAL;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            out_reg <= (agree & s3_reg) | (~agree & out_reg);
        end
    end

    assign sync_out = out_reg;
endmodule : tioc_sync

// ==== design/tioc_apb_regs.sv ====
/*
 * tioc_apb_regs: apb slave holding the device codes and showing status.
 * Assumes a 32-bit apb master on pclk; zero wait states.
 */
`timescale 1ns/1ps
module tioc_apb_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [tioc_pkg::TIOC_APB_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tioc_pkg::tioc_status_t status,
    output logic [tioc_pkg::TIOC_CODE_W-1:0] kbd_code,
    output logic [tioc_pkg::TIOC_CODE_W-1:0] prt_code
);
    import tioc_pkg::*;

    logic [TIOC_CODE_W-1:0] kbd_code_reg;
    logic [TIOC_CODE_W-1:0] prt_code_reg;

    // --------------------------------------------------------------
    // decode
    // --------------------------------------------------------------
    wire hit_codes = (paddr == TIOC_ADDR_CODES);
    wire hit_status = (paddr == TIOC_ADDR_STATUS);
    wire access = psel && penable;
    wire wr_codes = access && pwrite && hit_codes;
    wire [31:0] codes_word = {18'h0, prt_code_reg, 2'h0, kbd_code_reg};
    wire [31:0] status_word = {9'h0, status.prt_char, 1'b0, status.kbd_char,
                               4'h0, status.strobe_latch, status.irq_enable,
                               status.prt_flag, status.kbd_flag};

    assign pready = 1'b1;
    assign pslverr = access && !(hit_codes || (hit_status && !pwrite));
    assign prdata = (access && !pwrite && hit_codes) ? codes_word :
                    (access && !pwrite && hit_status) ? status_word : 32'h0000_0000;

    // code registers, written in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            kbd_code_reg <= TIOC_KBD_CODE_RST;
            prt_code_reg <= TIOC_PRT_CODE_RST;
        end else if (wr_codes) begin
            kbd_code_reg <= pwdata[TIOC_CODES_KBD_LSB +: TIOC_CODE_W];
            prt_code_reg <= pwdata[TIOC_CODES_PRT_LSB +: TIOC_CODE_W];
        end
    end

    assign kbd_code = kbd_code_reg;
    assign prt_code = prt_code_reg;
endmodule : tioc_apb_regs

// ==== bench/tioc_top_monitor.sv ====
/* tioc_top_monitor: port-level assertions for tioc_top.
   Assumes it is bound into tioc_top; one pclk domain. */
`timescale 1ns/1ps
module tioc_top_monitor (
    input wire logic pclk,
    input wire logic presetn,
    input wire tioc_pkg::tioc_iot_t iot,
    input wire logic [0:11] bus_data_out,
    input wire logic [0:11] bus_data_oe,
    input wire tioc_pkg::tioc_resp_t resp,
    input wire logic [6:0] printer_char,
    input wire logic printer_load_strobe_n
);
    import tioc_pkg::*;
    // ----------------
    // checks
    // ----------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic [2:0] op_w = iot.mem_data[9:11];
    wire logic rd_w = |bus_data_oe;
    a_claim_needs_iot: assert property (resp.internal_io_claim |-> iot.iot_active)
        else $error("claim without an i/o instruction");
    a_read_claims: assert property (rd_w |-> resp.internal_io_claim)
        else $error("data driven without claim");
    a_read_field: assert property (rd_w |-> bus_data_oe == 12'h0ff && bus_data_out[4])
        else $error("read field or mark bit wrong");
    a_read_ctl_b: assert property (rd_w |-> !resp.ac_transfer_ctl_b_n)
        else $error("read without second transfer control");
    a_ctl_a_pairs: assert property (!resp.ac_transfer_ctl_a_n |-> !resp.ac_transfer_ctl_b_n)
        else $error("first transfer control alone");
    a_skip_ops: assert property (resp.skip |-> iot.iot_active && op_w inside {3'h1, 3'h5})
        else $error("skip on a non-skip op");
    a_strobe_ts2: assert property (!printer_load_strobe_n |-> iot.time_state_two)
        else $error("load strobe outside time state two");
    a_pchar_tp3: assert property ($changed(printer_char) |-> $past(iot.timing_pulse_three))
        else $error("printer char changed without pulse three");
    c_strobe: cover property (!printer_load_strobe_n);
    c_read: cover property (rd_w);
    c_skip: cover property (resp.skip);
endmodule : tioc_top_monitor

bind tioc_top tioc_top_monitor mon_u (.pclk(pclk), .presetn(presetn), .iot(iot),
    .bus_data_out(bus_data_out), .bus_data_oe(bus_data_oe), .resp(resp),
    .printer_char(printer_char), .printer_load_strobe_n(printer_load_strobe_n));

// ==== bench/tioc_terminal_model.sv ====
/* tioc_terminal_model: behavioural printer-keyboard terminal.
   Assumes the bench pulses key_go; print time comes from print_cycles. */
`timescale 1ns/1ps
module tioc_terminal_model (
    input wire logic pclk,
    input wire logic [7:0] print_cycles,
    input wire logic key_go,
    input wire logic [6:0] key_val,
    input wire logic [6:0] printer_char,
    input wire logic printer_load_strobe_n,
    output logic printer_ready_request = 1'b0,
    output logic keyboard_char_strobe_n = 1'b1,
    output logic [6:0] keyboard_char = 7'h7f,
    output logic [6:0] printed = 7'h00
);
    logic [7:0] busy_reg = 8'h40;
    logic [4:0] key_reg = 5'h00;
    // ----------------
    // model
    // ----------------
    // strobe loads the buffer and drops ready until printing ends
    always @(posedge pclk) begin
        if (!printer_load_strobe_n) begin
            printed <= printer_char;
            printer_ready_request <= 1'b0;
            busy_reg <= print_cycles;
        end else if (busy_reg != 0) begin
            busy_reg <= busy_reg - 8'h01;
            printer_ready_request <= busy_reg == 8'h01;
        end
    end
    // char first, strobe low four cycles, hold, then lines go stale
    always @(posedge pclk) begin
        if (key_go && key_reg == 0) begin
            keyboard_char <= key_val;
            key_reg <= 5'h10;
        end else if (key_reg != 0) begin
            key_reg <= key_reg - 5'h01;
        end
        keyboard_char_strobe_n <= !(key_reg inside {[5'h0c:5'h0f]});
        if (key_reg == 5'h01) keyboard_char <= ~keyboard_char;
    end
endmodule : tioc_terminal_model

// ==== bench/tioc_top_bench.sv ====
/* tioc_top_bench: self-checking bench for tioc_top and a terminal model.
   Assumes a 50 MHz pclk and default device codes after reset. */
`timescale 1ns/1ps
module tioc_top_bench;
    import tioc_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, err, irq_n, ready, kstb_n, pstb_n, r_stb, key_go = 1'b0;
    tioc_iot_t iot = '0;
    tioc_resp_t resp, r_resp;
    logic [0:11] bus_data_in = 12'h000, bus_data_out, bus_data_oe, r_do, r_oe;
    logic [6:0] kchar, pchar, printed, key_val = 7'h00;
    int fails = 0, checks_done = 0;
    always #10 pclk = ~pclk;
    tioc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .iot(iot), .bus_data_in(bus_data_in), .bus_data_out(bus_data_out),
        .bus_data_oe(bus_data_oe), .resp(resp), .bus_interrupt_request_n(irq_n),
        .printer_ready_request(ready), .keyboard_char_strobe_n(kstb_n), .keyboard_char(kchar),
        .printer_char(pchar), .printer_load_strobe_n(pstb_n));
    tioc_terminal_model term_u (.pclk(pclk), .print_cycles(8'h06), .key_go(key_go),
        .key_val(key_val), .printer_char(pchar), .printer_load_strobe_n(pstb_n),
        .printer_ready_request(ready), .keyboard_char_strobe_n(kstb_n), .keyboard_char(kchar),
        .printed(printed));
    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    // one instruction: decode sampled, then pulse three, then idle
    task automatic io(input logic [5:0] c, input logic [2:0] op, input logic [11:0] ac);
        iot.iot_active <= 1'b1;
        iot.mem_data <= {3'h6, c, op};
        iot.time_state_two <= 1'b1;
        bus_data_in <= ac;
        @(posedge pclk);
        #1;
        r_resp = resp;
        r_do = bus_data_out;
        r_oe = bus_data_oe;
        r_stb = pstb_n;
        @(posedge pclk);
        iot.timing_pulse_three <= 1'b1;
        iot.time_state_two <= 1'b0;
        @(posedge pclk);
        iot.timing_pulse_three <= 1'b0;
        iot.iot_active <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask : io
    task automatic key(input logic [6:0] v);
        key_val <= v;
        key_go <= 1'b1;
        @(posedge pclk);
        key_go <= 1'b0;
        repeat (24) @(posedge pclk);
    endtask : key
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : wrap_up
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        chk(irq_n, 1'b1);
        apb(1'b0, TIOC_ADDR_CODES, 32'h0000_0000);
        chk(rd, 32'h0000_0403);
        apb(1'b0, TIOC_ADDR_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0004);
        apb(1'b0, 12'h008, 32'h0000_0000);
        chk(err, 1'b1);
        $display("test reset done");
    endtask : t_reset
    task automatic t_printer();
        wait (ready === 1'b1);
        repeat (6) @(posedge pclk);
        io(6'h04, TIOC_OP_PRT_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b1);
        chk(irq_n, 1'b0);
        io(6'h04, TIOC_OP_PRT_FLAG_CLEAR, 12'h000);
        io(6'h04, TIOC_OP_PRT_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b0);
        io(6'h04, TIOC_OP_PRT_FLAG_SET, 12'h000);
        io(6'h04, TIOC_OP_PRT_LOAD_AND_CLEAR, 12'hf5a);
        chk(pchar, 7'h5a);
        io(6'h04, TIOC_OP_PRT_FLAG_SKIP, 12'h000);
        chk(r_stb, 1'b0);
        chk(r_resp.skip, 1'b0);
        chk(printed, 7'h5a);
        repeat (16) @(posedge pclk);
        io(6'h04, TIOC_OP_PRT_LOAD, 12'h033);
        io(6'h04, TIOC_OP_PRT_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b1);
        chk(printed, 7'h33);
        $display("test printer done");
    endtask : t_printer
    task automatic t_keyboard();
        key(7'h41);
        io(6'h03, TIOC_OP_KBD_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b1);
        io(6'h03, TIOC_OP_KBD_OR_READ, 12'h000);
        chk({r_resp.ac_transfer_ctl_a_n, r_resp.ac_transfer_ctl_b_n}, 2'h2);
        chk(r_do[4:11], 8'hc1);
        io(6'h03, TIOC_OP_KBD_READ_CLEAR, 12'h000);
        chk({r_resp.ac_transfer_ctl_a_n, r_resp.ac_transfer_ctl_b_n, r_oe}, 14'h00ff);
        io(6'h03, TIOC_OP_KBD_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b0);
        io(6'h03, TIOC_OP_KBD_READ_CLEAR, 12'h000);
        chk(r_do[4:11], 8'hc1);
        key(7'h12);
        io(6'h03, TIOC_OP_KBD_FLAG_ACC_CLEAR, 12'h000);
        chk({r_resp.ac_transfer_ctl_a_n, r_resp.ac_transfer_ctl_b_n, r_oe}, 14'h0000);
        key(7'h7f);
        io(6'h03, TIOC_OP_KBD_FLAG_CLEAR, 12'h000);
        io(6'h03, TIOC_OP_KBD_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b0);
        $display("test keyboard done");
    endtask : t_keyboard
    task automatic t_irq();
        key(7'h55);
        io(6'h03, TIOC_OP_IRQ_ENABLE_WRITE, 12'hffe);
        io(6'h04, TIOC_OP_EITHER_FLAG_SKIP, 12'h000);
        chk({r_resp.skip, irq_n}, 2'h1);
        io(6'h03, TIOC_OP_IRQ_ENABLE_WRITE, 12'h001);
        io(6'h04, TIOC_OP_EITHER_FLAG_SKIP, 12'h000);
        chk({r_resp.skip, irq_n}, 2'h2);
        $display("test interrupt done");
    endtask : t_irq
    task automatic t_codes();
        apb(1'b1, TIOC_ADDR_CODES, 32'h0000_080b);
        io(6'h0b, TIOC_OP_KBD_FLAG_SKIP, 12'h000);
        chk({r_resp.internal_io_claim, r_resp.skip}, 2'h3);
        io(6'h03, TIOC_OP_KBD_FLAG_SKIP, 12'h000);
        chk(r_resp.internal_io_claim, 1'b0);
        io(6'h08, TIOC_OP_PRT_FLAG_SET, 12'h000);
        io(6'h08, TIOC_OP_PRT_FLAG_SKIP, 12'h000);
        chk(r_resp.skip, 1'b1);
        $display("test codes done");
    endtask : t_codes
    // watchdog
    initial begin
        repeat (20000) @(posedge pclk);
        fails++;
        wrap_up();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_printer();
        t_keyboard();
        t_irq();
        t_codes();
        wrap_up();
    end
endmodule : tioc_top_bench
